// ===== design/spp_params.svh
// Address, control word, field and timing constants of the status polled parallel port
`ifndef SPP_PARAMS_SVH
`define SPP_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define SPP_IDX_FIRST 8'hF4
`define SPP_IDX_SECOND 8'hF5
`define SPP_IDX_THIRD 8'hF6
`define SPP_IDX_CONTROL 8'hF7
`define SPP_IDX_LSB 2
`define SPP_IDX_MSB 9
`define SPP_CE_BIT 3

// ----------------------------------------------------------------------------
// Control port word layout
// ----------------------------------------------------------------------------
`define SPP_MODE_FLAG 7
`define SPP_FIRST_IN_BIT 4
`define SPP_UPPER_IN_BIT 3
`define SPP_SECOND_IN_BIT 1
`define SPP_LOWER_IN_BIT 0
`define SPP_BSR_SEL_MSB 3
`define SPP_BSR_SEL_LSB 1
`define SPP_BSR_LEVEL 0
`define SPP_MODE_RESET 8'h9B
`define SPP_INIT_CONFIG_WORD 8'h83

// ----------------------------------------------------------------------------
// Strobe set/reset words and busy masks of the third byte port
// ----------------------------------------------------------------------------
`define SPP_PRINTER_STROBE_ON_WORD 8'h0D
`define SPP_PRINTER_STROBE_OFF_WORD 8'h0C
`define SPP_PUNCH_STROBE_ON_WORD 8'h0B
`define SPP_PUNCH_STROBE_OFF_WORD 8'h0A
`define SPP_READER_STROBE_ON_WORD 8'h09
`define SPP_READER_STROBE_OFF_WORD 8'h08
`define SPP_PRINTER_BUSY_MASK 8'h04
`define SPP_PUNCH_BUSY_MASK 8'h02
`define SPP_READER_BUSY_MASK 8'h01

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SPP_CLK_MHZ 100
`define SPP_STROBE_MIN_NS 500
`define SPP_STROBE_MIN_CYC ((`SPP_STROBE_MIN_NS * `SPP_CLK_MHZ + 999) / 1000)

`endif

// ===== design/spp_pkg.sv
// Types shared by the status polled parallel port modules
package spp_pkg;

    // ------------------------------------------------------------------------
    // Port select, bus state and buffered command
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        SPP_SEL_FIRST = 2'b00,
        SPP_SEL_SECOND = 2'b01,
        SPP_SEL_THIRD = 2'b10,
        SPP_SEL_CONTROL = 2'b11
    } spp_sel_t;

    typedef enum logic [1:0] {
        SPP_ST_IDLE = 2'b00,
        SPP_ST_WRITE = 2'b01,
        SPP_ST_READ = 2'b10
    } spp_bus_st_t;

    typedef struct packed {
        spp_sel_t sel;
        logic [7:0] data;
    } spp_cmd_t;

endpackage

// ===== design/spp_cmd_if.sv
// Valid/ready carrier for port write commands
`timescale 1ns/100ps
`default_nettype none

interface spp_cmd_if;
    import spp_pkg::*;
    logic valid;
    logic ready;
    spp_cmd_t cmd;

    modport src (output valid, output cmd, input ready);
    modport dst (input valid, input cmd, output ready);
endinterface

`default_nettype wire

// ===== design/spp_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module spp_sync import spp_pkg::*; #(
    parameter int WIDTH = 24
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Pins and filtered levels
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);

    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            level <= '0;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // Stage one is never looked at directly
            level <= (s2_r & s3_r) | (level & (s2_r | s3_r));
        end
    end

endmodule

`default_nettype wire

// ===== design/spp_buf.sv
// Small valid/ready command buffer between the bus slave and the port engine
`timescale 1ns/100ps
`default_nettype none

module spp_buf import spp_pkg::*; #(
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Filling and draining sides
    spp_cmd_if.dst up,
    spp_cmd_if.src dn
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    spp_cmd_t mem_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0] cnt_r;
    logic push;
    logic pop;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    assign up.ready = (cnt_r != (PW+1)'(DEPTH));
    assign dn.valid = (cnt_r != '0);
    assign dn.cmd = mem_r[rd_ptr_r];
    assign push = up.valid && up.ready;
    assign pop = dn.valid && dn.ready;

    always_ff @(posedge hclk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= up.cmd;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= ptr_inc(wr_ptr_r);
            end
            if (pop) begin
                rd_ptr_r <= ptr_inc(rd_ptr_r);
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ===== design/spp_top.sv
// Status polled parallel port: AHB-Lite slave, port latches and direction control
//
// The address map and register access over AHB-Lite were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "spp_params.svh"

module spp_top import spp_pkg::*; (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // First byte port (printer and punch data)
    input wire logic [7:0] first_byte_port_in,
    output logic [7:0] first_byte_port_out,
    output logic [7:0] first_byte_port_oe,
    // Second byte port (reader data)
    input wire logic [7:0] second_byte_port_in,
    output logic [7:0] second_byte_port_out,
    output logic [7:0] second_byte_port_oe,
    // Third byte port (strobes and busy lines)
    input wire logic [7:0] third_byte_port_in,
    output logic [7:0] third_byte_port_out,
    output logic [7:0] third_byte_port_oe
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    spp_bus_st_t bus_st_r;
    spp_sel_t sel_r;
    logic hit_r;
    logic take;
    logic [7:0] idx;
    logic [23:0] pin_level;
    logic [7:0] first_sync;
    logic [7:0] second_sync;
    logic [7:0] third_sync;
    logic [7:0] hold_r;
    logic pop;
    logic [7:0] rd_byte;
    logic [7:0] mode_word;
    logic [7:0] cmd_data;
    spp_sel_t cmd_sel;

    spp_cmd_if wr_if ();
    spp_cmd_if eng_if ();

    // Byte read back from a port: latch on driven bits, pin on input bits
    function automatic logic [7:0] mix(input logic [7:0] lat, input logic [7:0] pin,
                                       input logic [7:0] oe);
        mix = (lat & oe) | (pin & ~oe);
    endfunction

    // ------------------------------------------------------------------------
    // Pin synchronisers and command buffer
    // ------------------------------------------------------------------------
    spp_sync #(
        .WIDTH(24)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin({third_byte_port_in, second_byte_port_in, first_byte_port_in}),
        .level(pin_level)
    );

    assign first_sync = pin_level[7:0];
    assign second_sync = pin_level[15:8];
    assign third_sync = pin_level[23:16];

    // Writes queue here so a strobe hold never stalls the bus beyond two words
    spp_buf #(
        .DEPTH(2)
    ) u_buf (
        .hclk(hclk),
        .hresetn(hresetn),
        .up(wr_if.dst),
        .dn(eng_if.src)
    );

    // ------------------------------------------------------------------------
    // AHB-Lite address decode and data phase
    // ------------------------------------------------------------------------
    assign idx = haddr[`SPP_IDX_MSB:`SPP_IDX_LSB];
    assign take = hsel && hready && htrans[1] && (bus_st_r == SPP_ST_IDLE);

    assign wr_if.valid = (bus_st_r == SPP_ST_WRITE) && hit_r;
    assign wr_if.cmd = '{sel: sel_r, data: hwdata[7:0]};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_st_r <= SPP_ST_IDLE;
            sel_r <= SPP_SEL_FIRST;
            hit_r <= 1'b0;
            hreadyout <= 1'b1;
        end else begin
            case (bus_st_r)
                SPP_ST_IDLE: begin
                    if (take) begin
                        // Chip enable is active low, linear select
                        hit_r <= !idx[`SPP_CE_BIT];
                        sel_r <= spp_sel_t'(idx[1:0]);
                        hreadyout <= 1'b0;
                        bus_st_r <= hwrite ? SPP_ST_WRITE : SPP_ST_READ;
                    end
                end
                SPP_ST_WRITE: begin
                    if (!hit_r || wr_if.ready) begin
                        hreadyout <= 1'b1;
                        bus_st_r <= SPP_ST_IDLE;
                    end
                end
                SPP_ST_READ: begin
                    // Reads wait for queued writes so they never see stale latches
                    if (!eng_if.valid) begin
                        hreadyout <= 1'b1;
                        bus_st_r <= SPP_ST_IDLE;
                    end
                end
                default: begin
                    hreadyout <= 1'b1;
                    bus_st_r <= SPP_ST_IDLE;
                end
            endcase
        end
    end

    assign mode_word = {1'b1, 2'b00, ~first_byte_port_oe[0], ~third_byte_port_oe[7], 1'b0,
                        ~second_byte_port_oe[0], ~third_byte_port_oe[0]};

    always_comb begin
        case (sel_r)
            SPP_SEL_SECOND: rd_byte = mix(second_byte_port_out, second_sync,
                                          second_byte_port_oe);
            // Busy inputs live, strobe latches as driven
            SPP_SEL_THIRD: rd_byte = mix(third_byte_port_out, third_sync, third_byte_port_oe);
            SPP_SEL_CONTROL: rd_byte = mode_word;
            default: rd_byte = mix(first_byte_port_out, first_sync, first_byte_port_oe);
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (bus_st_r == SPP_ST_READ && !eng_if.valid) begin
            hrdata <= hit_r ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Port engine: drains the buffer and applies each write
    // ------------------------------------------------------------------------
    assign cmd_sel = eng_if.cmd.sel;
    assign cmd_data = eng_if.cmd.data;
    // A strobe edge is held at least the minimum pulse before the next command
    assign eng_if.ready = (hold_r == 8'h00);
    assign pop = eng_if.valid && eng_if.ready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_r <= 8'h00;
        end else if (pop && (cmd_sel == SPP_SEL_THIRD || cmd_sel == SPP_SEL_CONTROL)) begin
            hold_r <= 8'(`SPP_STROBE_MIN_CYC - 1);
        end else if (hold_r != 8'h00) begin
            hold_r <= hold_r - 8'h01;
        end
    end

    // Direction: reset leaves every line an input until software configures
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            first_byte_port_oe <= 8'h00;
            second_byte_port_oe <= 8'h00;
            third_byte_port_oe <= 8'h00;
        end else if (pop && cmd_sel == SPP_SEL_CONTROL && cmd_data[`SPP_MODE_FLAG]) begin
            // Basic mode only; group mode bits are ignored
            first_byte_port_oe <= {8{~cmd_data[`SPP_FIRST_IN_BIT]}};
            second_byte_port_oe <= {8{~cmd_data[`SPP_SECOND_IN_BIT]}};
            third_byte_port_oe <= {{4{~cmd_data[`SPP_UPPER_IN_BIT]}},
                                   {4{~cmd_data[`SPP_LOWER_IN_BIT]}}};
        end
    end

    // Output latches; positive logic straight to the data lines
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            first_byte_port_out <= 8'h00;
            second_byte_port_out <= 8'h00;
            third_byte_port_out <= 8'h00;
        end else if (pop) begin
            case (cmd_sel)
                SPP_SEL_FIRST: first_byte_port_out <= cmd_data;
                SPP_SEL_SECOND: second_byte_port_out <= cmd_data;
                SPP_SEL_THIRD: third_byte_port_out <= cmd_data;
                SPP_SEL_CONTROL: begin
                    if (cmd_data[`SPP_MODE_FLAG]) begin
                        // A configuration word clears every latch
                        first_byte_port_out <= 8'h00;
                        second_byte_port_out <= 8'h00;
                        third_byte_port_out <= 8'h00;
                    end else begin
                        // Single bit set/reset, other bits kept
                        third_byte_port_out[cmd_data[`SPP_BSR_SEL_MSB:`SPP_BSR_SEL_LSB]]
                            <= cmd_data[`SPP_BSR_LEVEL];
                    end
                end
                default: first_byte_port_out <= first_byte_port_out;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    a_init_config_dirs: assert property (@(posedge hclk) disable iff (!hresetn)
        pop && cmd_sel == SPP_SEL_CONTROL && cmd_data == `SPP_INIT_CONFIG_WORD |=>
        first_byte_port_oe == 8'hFF && second_byte_port_oe == 8'h00 &&
        third_byte_port_oe == 8'hF0 && third_byte_port_out == 8'h00)
        else $error("configuration word did not set port directions");

    a_second_port_read: assert property (@(posedge hclk) disable iff (!hresetn)
        bus_st_r == SPP_ST_READ && !eng_if.valid && hit_r && sel_r == SPP_SEL_SECOND &&
        second_byte_port_oe == 8'h00 |=> hrdata[7:0] == $past(second_sync) && hreadyout)
        else $error("second port read did not return reader lines");

    a_busy_bits_read: assert property (@(posedge hclk) disable iff (!hresetn)
        bus_st_r == SPP_ST_READ && !eng_if.valid && hit_r && sel_r == SPP_SEL_THIRD &&
        third_byte_port_oe[2:0] == 3'h0 |=> hrdata[2:0] == $past(third_sync[2:0]))
        else $error("busy bits read back wrong");

    a_printer_strobe_set: assert property (@(posedge hclk) disable iff (!hresetn)
        pop && cmd_sel == SPP_SEL_CONTROL && cmd_data == `SPP_PRINTER_STROBE_ON_WORD |=>
        third_byte_port_out[6] && third_byte_port_out[5:0] == $past(third_byte_port_out[5:0]))
        else $error("printer strobe set word failed");

    a_bsr_keeps_dirs: assert property (@(posedge hclk) disable iff (!hresetn)
        pop && cmd_sel == SPP_SEL_CONTROL && !cmd_data[7] |=>
        $stable(third_byte_port_oe) && $stable(first_byte_port_out) &&
        $stable(first_byte_port_oe))
        else $error("set/reset word disturbed other state");

    a_strobe_min_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        pop && cmd_sel == SPP_SEL_CONTROL |=> !pop [*8])
        else $error("command issued inside strobe hold");

    a_chip_enable_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        take && hwrite && haddr[`SPP_IDX_LSB + `SPP_CE_BIT] |=> !wr_if.valid ##1 hreadyout)
        else $error("unselected write reached the port");

    a_port_write_data: assert property (@(posedge hclk) disable iff (!hresetn)
        pop && cmd_sel == SPP_SEL_FIRST |=> first_byte_port_out == $past(cmd_data))
        else $error("first port latch not updated");

    a_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn)
        !hresp)
        else $error("slave answered other than OKAY");

endmodule

`default_nettype wire

// ===== verification/spp_periph_model.sv
// Behavioural printer, tape punch and tape reader seen from the port pins
`timescale 1ns/100ps
`default_nettype none

module spp_periph_model #(
    // Outlasts the strobe hold, so a poll after the closing strobe word still sees busy
    parameter int BUSY_CYC = 80
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Pin levels from the port
    input wire logic [7:0] data_pins,
    input wire logic [2:0] strobe_pins,
    // Lines back to the port
    output logic [2:0] busy,
    output logic [7:0] track,
    // Observed results
    output logic [7:0] printed,
    output logic [7:0] punched,
    output logic [7:0] rd_char,
    output int print_cnt,
    output int min_low,
    output int viol
);
    logic [2:0] prev_r;
    int low_r;
    int ptmr_r;
    int ntmr_r;
    int rtmr_r;

    assign busy = {ptmr_r != 0, ntmr_r != 0, rtmr_r != 0};
    // Track lines are stale while a character is being read, so show the inverse then
    assign track = (rtmr_r != 0) ? ~rd_char : rd_char;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_r <= 3'h7;
            low_r <= 0;
            ptmr_r <= 0;
            ntmr_r <= 0;
            rtmr_r <= 0;
            printed <= 8'h00;
            punched <= 8'h00;
            rd_char <= 8'h3C;
            print_cnt <= 0;
            min_low <= 1000000;
            viol <= 0;
        end else begin
            prev_r <= strobe_pins;
            low_r <= strobe_pins[2] ? 0 : low_r + 1;
            if (ptmr_r != 0) ptmr_r <= ptmr_r - 1;
            if (ntmr_r != 0) ntmr_r <= ntmr_r - 1;
            if (rtmr_r != 0) rtmr_r <= rtmr_r - 1;
            if (rtmr_r == 1) rd_char <= rd_char + 8'h11;
            // Printer takes the character as its low true strobe ends
            if (!prev_r[2] && strobe_pins[2]) begin
                printed <= data_pins;
                print_cnt <= print_cnt + 1;
                ptmr_r <= BUSY_CYC;
                if (low_r < min_low) min_low <= low_r;
            end
            if (prev_r[2] && !strobe_pins[2] && ptmr_r != 0) viol <= viol + 1;
            // Punch fires on its high true command
            if (!prev_r[1] && strobe_pins[1]) begin
                punched <= data_pins;
                ntmr_r <= BUSY_CYC;
            end
            // Reader starts a character on its low true drive line
            if (prev_r[0] && !strobe_pins[0]) rtmr_r <= BUSY_CYC;
        end
    end
endmodule

`default_nettype wire

// ===== verification/test_status_polled_parallel_port.sv
// Self-checking bench for the status polled parallel port
`timescale 1ns/100ps
`default_nettype none
`include "spp_params.svh"

module test_status_polled_parallel_port import spp_pkg::*;;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [7:0] a_in, a_out, a_oe, b_in, b_out, b_oe, c_in, c_out, c_oe;
    logic [7:0] track, printed, punched, rd_char;
    logic [2:0] busy;
    int print_cnt, min_low, viol;
    int miscompares = 0;
    int cmp_count = 0;

    // ------------------------------------------------------------------------
    // Wire levels: undriven first port lines and third port lines 7 to 3 show the inverse of the latch; the rest show track and busy
    // ------------------------------------------------------------------------
    assign a_in = (a_out & a_oe) | (~a_out & ~a_oe);
    assign b_in = (b_out & b_oe) | (track & ~b_oe);
    assign c_in = (c_out & c_oe) | ({~c_out[7:3], busy} & ~c_oe);

    spp_top spp_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .first_byte_port_in(a_in), .first_byte_port_out(a_out), .first_byte_port_oe(a_oe),
        .second_byte_port_in(b_in), .second_byte_port_out(b_out), .second_byte_port_oe(b_oe),
        .third_byte_port_in(c_in), .third_byte_port_out(c_out), .third_byte_port_oe(c_oe));

    spp_periph_model spp_periph_model_inst (.hclk(hclk), .hresetn(hresetn),
        .data_pins(a_in), .strobe_pins(c_in[6:4]), .busy(busy), .track(track),
        .printed(printed), .punched(punched), .rd_char(rd_char), .print_cnt(print_cnt),
        .min_low(min_low), .viol(viol));

    initial hclk = 1'h0;
    always #5 hclk = ~hclk;

    // ------------------------------------------------------------------------
    // Bus access and comparison tasks
    // ------------------------------------------------------------------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chkn(input int got, input int exp, input string what);
        cmp_count++;
        if (got != exp) begin
            miscompares++;
            $display("MISMATCH at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask

    task automatic fail_out(input string what);
        miscompares++;
        $display("MISMATCH at %0t: %s", $time, what);
        report_and_stop();
    endtask

    task automatic wait_ready(output int n);
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'h1 && n < 300) begin
            n++;
            @(posedge hclk);
        end
        if (n >= 300) fail_out("bus wait ran out");
    endtask

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd, output int waits);
        int n;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready(n);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_ready(waits);
        rd = hrdata[7:0];
        chk8({7'h00, hresp}, 8'h00, "response");
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] r;
        int w;
        bus(1'h1, idx, d, r, w);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [7:0] d);
        int w;
        bus(1'h0, idx, 8'h00, d, w);
    endtask

    // Reads the third port until the masked busy line shows the wanted level
    task automatic poll(input logic [7:0] mask, input logic want);
        logic [7:0] r;
        int n;
        n = 0;
        rd(`SPP_IDX_THIRD, r);
        while (((r & mask) !== 8'h00) !== want && n < 100) begin
            n++;
            rd(`SPP_IDX_THIRD, r);
        end
        if (n >= 100) fail_out("busy line never reached level");
    endtask

    task automatic report_and_stop();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        logic [7:0] r, exp;
        logic [7:0] words [8];
        logic [7:0] chars [2];
        int w, k, n0;
        words = '{`SPP_PUNCH_STROBE_ON_WORD, `SPP_PUNCH_STROBE_OFF_WORD,
                  `SPP_PRINTER_STROBE_OFF_WORD, `SPP_PRINTER_STROBE_ON_WORD,
                  `SPP_READER_STROBE_OFF_WORD, `SPP_READER_STROBE_ON_WORD, 8'h0F, 8'h0E};
        chars = '{8'hA5, 8'h5A};
        hresetn = 1'h0;
        hsel = 1'h1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        rd(`SPP_IDX_CONTROL, r);
        chk8(r, `SPP_MODE_RESET, "reset mode");
        chk8(c_oe, 8'h00, "reset third enables");
        wr(`SPP_IDX_CONTROL | 8'h08, `SPP_INIT_CONFIG_WORD);
        rd(`SPP_IDX_CONTROL | 8'h08, r);
        chk8(r, 8'h00, "unselected read");
        rd(`SPP_IDX_CONTROL, r);
        chk8(r, `SPP_MODE_RESET, "unselected write dropped");
        $display("Test reset and chip enable done");

        wr(`SPP_IDX_CONTROL, `SPP_INIT_CONFIG_WORD);
        wr(`SPP_IDX_CONTROL, `SPP_PRINTER_STROBE_ON_WORD);
        wr(`SPP_IDX_CONTROL, `SPP_READER_STROBE_ON_WORD);
        rd(`SPP_IDX_CONTROL, r);
        chk8(r, `SPP_INIT_CONFIG_WORD, "mode readback");
        chk8(a_oe, 8'hFF, "first enables");
        chk8(b_oe, 8'h00, "second enables");
        chk8(b_out, 8'h00, "second latch cleared");
        chk8(c_oe, 8'hF0, "third enables");
        chk8(c_out, 8'h50, "strobes idle");
        $display("Test configuration done");

        exp = 8'h50;
        for (k = 0; k < 8; k++) begin
            wr(`SPP_IDX_CONTROL, words[k]);
            exp[words[k][3:1]] = words[k][0];
            rd(`SPP_IDX_THIRD, r);
            chk8(c_out, exp, "third latch");
            chk8({r[7:4], 4'h0}, {exp[7:4], 4'h0}, "third readback");
        end
        chk8(a_oe, 8'hFF, "first enables kept");
        chk8(c_oe, 8'hF0, "third enables kept");
        $display("Test set and reset done");

        for (k = 0; k < 4; k++) begin
            bus(1'h1, `SPP_IDX_CONTROL, words[k % 2], r, w);
        end
        chkn(int'(w > 10), 1, "full buffer stalls writer");
        bus(1'h0, `SPP_IDX_THIRD, 8'h00, r, w);
        chkn(int'(w > 10), 1, "read waits for drain");
        chk8(c_out, 8'h50, "burst result");
        $display("Test buffer done");

        n0 = print_cnt;
        for (k = 0; k < 2; k++) begin
            poll(`SPP_PRINTER_BUSY_MASK, 1'h0);
            wr(`SPP_IDX_FIRST, chars[k]);
            wr(`SPP_IDX_CONTROL, `SPP_PRINTER_STROBE_OFF_WORD);
            wr(`SPP_IDX_CONTROL, `SPP_PRINTER_STROBE_ON_WORD);
            poll(`SPP_PRINTER_BUSY_MASK, 1'h1);
            chk8(a_out, chars[k], "printer data");
            chk8(printed, chars[k], "printed");
        end
        chkn(print_cnt - n0, 2, "characters printed");
        chkn(viol, 0, "strobe while busy");
        chkn(int'(min_low >= `SPP_STROBE_MIN_CYC), 1, "strobe width");
        $display("Test printer done");

        poll(`SPP_PUNCH_BUSY_MASK, 1'h0);
        wr(`SPP_IDX_FIRST, 8'hC3);
        wr(`SPP_IDX_CONTROL, `SPP_PUNCH_STROBE_ON_WORD);
        wr(`SPP_IDX_CONTROL, `SPP_PUNCH_STROBE_OFF_WORD);
        poll(`SPP_PUNCH_BUSY_MASK, 1'h1);
        chk8(punched, 8'hC3, "punched");
        $display("Test punch done");

        wr(`SPP_IDX_CONTROL, `SPP_READER_STROBE_OFF_WORD);
        poll(`SPP_READER_BUSY_MASK, 1'h1);
        poll(`SPP_READER_BUSY_MASK, 1'h0);
        rd(`SPP_IDX_SECOND, r);
        chk8(r, rd_char, "reader character");
        wr(`SPP_IDX_CONTROL, `SPP_READER_STROBE_ON_WORD);
        rd(`SPP_IDX_THIRD, r);
        chk8(c_out, 8'h50, "strobes idle again");
        $display("Test reader done");
        report_and_stop();
    end
endmodule

`default_nettype wire
